/* File: src/qee_pkg.sv */
// Purpose : Shared constants for the quadrature encoder emulator.
// Assumes : 20 MHz system clock.
// Notes   : All offsets, codes and timing counts live here.
package qee_pkg;
   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned MAX_PULSE_HZ    = 1_000_000;
   // One output period holds four phase slots; slot length rounds up.
   localparam int unsigned SLOT_CYC_CALC   = (CLK_HZ + 4 * MAX_PULSE_HZ - 1) / (4 * MAX_PULSE_HZ);
   localparam int unsigned SLOT_CYC        = (SLOT_CYC_CALC < 1) ? 1 : SLOT_CYC_CALC;
   localparam int unsigned INDEX_US        = 5;
   localparam int unsigned INDEX_CYC       = INDEX_US * (CLK_HZ / 1_000_000);
   localparam logic [7:0]  SLOT_LAST       = 8'(SLOT_CYC - 1);
   localparam logic [7:0]  INDEX_LAST      = 8'(INDEX_CYC - 1);
   // ==========================================================
   // Widths and codes
   // ==========================================================
   localparam int unsigned ANG_W           = 15;
   localparam int unsigned POS_W           = 12;
   localparam logic [1:0]  RES_12BIT       = 2'h0;
   localparam logic [1:0]  RES_11BIT       = 2'h1;
   localparam logic [1:0]  RES_10BIT       = 2'h2;
   localparam logic [1:0]  RES_9BIT        = 2'h3;
   localparam logic        MODE_QUAD       = 1'b0;
   localparam logic        MODE_STEPDIR    = 1'b1;
   localparam logic        DIR_CW          = 1'b1;
   localparam logic [POS_W-1:0] POS_ZERO   = 12'h000;
endpackage

/* File: src/qee_step_if.sv */
// Purpose : Carries one step request and its acknowledge between modules.
// Assumes : Single clock domain.
// Notes   : The emitter raises done for one cycle per finished step.
`timescale 1ns/1ns
interface qee_step_if;
   logic req;
   logic dir;
   logic done;
   modport gen  (output req, output dir, input done);
   modport emit (input req, input dir, output done);
endinterface

/* File: src/qee_pulse_emitter.sv */
// Purpose : Turns step requests into rate-limited A/B or step/direction edges.
// Assumes : Requests are held until done pulses.
// Notes   : Each step takes four equal slots and a latch cycle, so at most 1 MHz; step/dir A is high for two slots.
`timescale 1ns/1ns
module qee_pulse_emitter
   import qee_pkg::*;
(
   input  wire logic i_mclk,
   input  wire logic i_sys_rst,
   input  wire logic i_mode,
   qee_step_if.emit  step,
   output logic      o_a,
   output logic      o_b
);
   // ==========================================================
   // Slot timer and phase counter
   // ==========================================================
   logic [7:0] slot_cnt_ff;
   logic [1:0] phase_ff;
   logic       busy_ff;
   logic       dir_ff;
   logic [1:0] quad_ff;
   logic       slot_end;

   assign slot_end  = busy_ff && (slot_cnt_ff == SLOT_LAST); // R9
   assign step.done = slot_end && (phase_ff == 2'h3);

   // Latch a new step and walk through four slots; direction is frozen per step.
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         busy_ff     <= 1'b0;
         slot_cnt_ff <= 8'h00;
         phase_ff    <= 2'h0;
         dir_ff      <= DIR_CW;
      end else if (!busy_ff) begin
         if (step.req) begin
            busy_ff     <= 1'b1;
            dir_ff      <= step.dir;
            slot_cnt_ff <= 8'h00;
            phase_ff    <= 2'h0;
         end
      end else if (slot_end) begin
         slot_cnt_ff <= 8'h00;
         phase_ff    <= phase_ff + 2'h1;
         if (phase_ff == 2'h3) begin
            busy_ff <= 1'b0;
         end
      end else begin
         slot_cnt_ff <= slot_cnt_ff + 8'h01;
      end
   end

   // Gray state of the quadrature pair; it moves one notch per slot pair.
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         quad_ff <= 2'h0;
      end else if (slot_end && phase_ff[0]) begin
         // CW: B leads so A lags; CCW the reverse.
         if (dir_ff == DIR_CW) begin
            quad_ff <= {quad_ff[0], ~quad_ff[1]}; // R5
         end else begin
            quad_ff <= {~quad_ff[0], quad_ff[1]}; // R5
         end
      end
   end

   // ==========================================================
   // Output stage
   // ==========================================================
   // Outputs are registered so the pins never glitch on mode changes.
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_a <= 1'b0;
         o_b <= 1'b0;
      end else if (i_mode == MODE_STEPDIR) begin
         o_a <= busy_ff && !phase_ff[1]; // R1 R6
         o_b <= busy_ff ? dir_ff : step.dir; // R13
      end else begin
         o_a <= quad_ff[1]; // R1 R3
         o_b <= quad_ff[0]; // R3
      end
   end
endmodule

/* File: src/qee_top.sv */
// Purpose : Incremental output stage emulating an optical quadrature encoder.
// Assumes : Angle arrives as a 15-bit unsigned word synchronous to i_mclk.
// Notes   : Config fields are plain inputs; there is no software bus here.
// Behaviour
// R1 - One square pulse per angle step, 50% duty on incremental channels. In quadrature mode each channel gives one pulse per two steps.
// R2 - Resolution selectable from 9 bits (512) to 12 bits (4096 steps).
// R3 - Direction shown by A/B phase or by channel B level.
// R4 - Encoder mode select chooses quadrature or step/direction operation.
// R5 - Quadrature: clockwise makes A lag B, counterclockwise makes B lag A.
// R6 - Step/direction: A pulses per increment, B holds direction level.
// R7 - After startup, burst of pulses equal to the absolute angle.
// R8 - Index pulse on third output whenever angle crosses zero. The code gives no index while the startup burst runs.
// R9 - Channel pulse rate never exceeds one megahertz.
// R10 - Controller counts pulses up or down to track position.
// R11 - Controller may read angle serially and add difference to resync.
// R12 - Resolution codes 0..3 give 12, 11, 10, 9 bit steps.
// R13 - Step/direction: B high for clockwise, settled before next A edge.
`timescale 1ns/1ns
module qee_top
   import qee_pkg::*;
(
   input  wire logic             i_mclk,
   input  wire logic             i_sys_rst,
   input  wire logic [ANG_W-1:0] i_angle_value,
   input  wire logic             i_angle_valid,
   input  wire logic [1:0]       i_step_resolution_sel,
   input  wire logic             i_encoder_mode_sel,
   output logic                  o_quad_out_a,
   output logic                  o_quad_out_b,
   output logic                  o_index_out,
   output logic                  o_startup_done
);
   // ==========================================================
   // Position scaling
   // ==========================================================
   logic [POS_W-1:0] target_pos;
   logic [POS_W-1:0] pos_mask;
   logic [POS_W-1:0] out_pos_ff;
   logic [POS_W-1:0] diff;
   logic             have_angle_ff;
   logic             startup_ff;
   logic [7:0]       idx_cnt_ff;
   logic             idx_on_ff;
   logic             step_up;
   logic             wrap;
   logic             step_act_ff;
   logic             step_dir_ff;

   qee_step_if step_bus ();

   // Scale the angle to the chosen step count, left-aligned to 12 bits.
   always_comb begin
      case (i_step_resolution_sel) // R2 R12
         RES_12BIT: pos_mask = 12'hFFF;
         RES_11BIT: pos_mask = 12'hFFE;
         RES_10BIT: pos_mask = 12'hFFC;
         RES_9BIT:  pos_mask = 12'hFF8;
         default:   pos_mask = 12'hFFF;
      endcase
      target_pos = i_angle_value[ANG_W-1 -: POS_W] & pos_mask;
   end

   // One step is the LSB weight of the current resolution.
   logic [POS_W-1:0] step_w;
   assign step_w  = (~pos_mask) + 12'h001;
   assign diff    = target_pos - out_pos_ff;
   // Shortest path round the circle: lower half of the difference is forward.
   assign step_up = !diff[POS_W-1];
   assign step_bus.req = have_angle_ff && ((out_pos_ff & pos_mask) != target_pos);
   assign step_bus.dir = startup_ff ? DIR_CW : step_up; // R7

   // Mirror of the emitter's step latch. The angle may move in mid step and flip the live
   // direction, so position and index must follow the direction the pins actually show.
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         step_act_ff <= 1'b0;
         step_dir_ff <= DIR_CW;
      end else if (step_bus.done) begin
         step_act_ff <= 1'b0;
      end else if (!step_act_ff && step_bus.req) begin
         step_act_ff <= 1'b1;
         step_dir_ff <= step_bus.dir; // R3
      end
   end

   // ==========================================================
   // Tracked output position
   // ==========================================================
   // The startup burst counts up from zero to the absolute angle. R7
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         out_pos_ff    <= POS_ZERO;
         have_angle_ff <= 1'b0;
         startup_ff    <= 1'b1;
      end else begin
         if (i_angle_valid) begin
            have_angle_ff <= 1'b1;
         end
         if (step_bus.done) begin
            out_pos_ff <= step_dir_ff ? ((out_pos_ff & pos_mask) + step_w) // R1
                                       : ((out_pos_ff & pos_mask) - step_w);
         end
         if (have_angle_ff && !step_bus.req) begin
            startup_ff <= 1'b0; // R7
         end
      end
   end

   // A step through zero in either direction marks the index once startup is over. R8
   assign wrap = step_bus.done && !startup_ff &&
                 (step_dir_ff ? (((out_pos_ff & pos_mask) + step_w) == POS_ZERO)
                               : ((out_pos_ff & pos_mask) == POS_ZERO));

   // ==========================================================
   // Index pulse stretcher
   // ==========================================================
   // Held for the typical index width so a slow counter still sees it.
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         idx_on_ff  <= 1'b0;
         idx_cnt_ff <= 8'h00;
      end else if (wrap) begin
         idx_on_ff  <= 1'b1; // R8
         idx_cnt_ff <= 8'h00;
      end else if (idx_on_ff) begin
         if (idx_cnt_ff == INDEX_LAST) begin
            idx_on_ff <= 1'b0;
         end else begin
            idx_cnt_ff <= idx_cnt_ff + 8'h01;
         end
      end
   end

   assign o_index_out    = idx_on_ff;
   assign o_startup_done = !startup_ff;

   // The emitter paces every step in four slots, which caps the rate. R9
   qee_pulse_emitter u_emit (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .i_mode    (i_encoder_mode_sel), // R4
      .step      (step_bus.emit),
      .o_a       (o_quad_out_a),
      .o_b       (o_quad_out_b)
   );
endmodule

/* File: verif/qee_counter_model.sv */
// Purpose : Up/down pulse counter standing in for the host controller.
// Assumes : Both channels are sampled on every rising clock edge.
// Notes   : Counts half steps so that both modes share one scale.
`timescale 1ns/1ns
module qee_counter_model
   import qee_pkg::*;
(
   input  wire logic          i_mclk,
   input  wire logic          i_sys_rst,
   input  wire logic          i_a,
   input  wire logic          i_b,
   input  wire logic          i_mode,
   output logic signed [15:0] o_half_steps
);
   // =========================================================
   // A quadrature step is two gray moves, so a pulse counts two.
   logic [1:0] ab_ff;
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ab_ff        <= 2'h0;
         o_half_steps <= 16'sh0;
      end else begin
         ab_ff <= {i_a, i_b};
         if (i_mode && i_a && !ab_ff[1]) begin
            o_half_steps <= o_half_steps + ((i_b == DIR_CW) ? 16'sh2 : -16'sh2);
         end else if (!i_mode && {i_a, i_b} == {ab_ff[0], ~ab_ff[1]}) begin
            o_half_steps <= o_half_steps + 16'sh1;
         end else if (!i_mode && ab_ff == {i_b, ~i_a}) begin
            o_half_steps <= o_half_steps - 16'sh1;
         end
      end
   end
endmodule

/* File: verif/qee_top_properties.sv */
// Purpose : Concurrent checks on the emulator's output pins.
// Assumes : Mode and resolution only change while reset is held.
// Notes   : Small counters replace long repetitions.
`timescale 1ns/1ns
module qee_top_properties
   import qee_pkg::*;
(
   input wire logic             i_mclk,
   input wire logic             i_sys_rst,
   input wire logic [ANG_W-1:0] i_angle_value,
   input wire logic             i_angle_valid,
   input wire logic [1:0]       i_step_resolution_sel,
   input wire logic             i_encoder_mode_sel,
   input wire logic             o_quad_out_a,
   input wire logic             o_quad_out_b,
   input wire logic             o_index_out,
   input wire logic             o_startup_done
);
   // =========================================================
   // Cycles since the last A rise, and length of the index pulse.
   logic [7:0] gap_ff;
   logic [7:0] hi_ff;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         gap_ff <= 8'hff;
         hi_ff  <= 8'h00;
      end else begin
         gap_ff <= $rose(o_quad_out_a) ? 8'h00 : gap_ff + {7'h0, gap_ff != 8'hff};
         hi_ff  <= o_index_out ? hi_ff + 8'h01 : 8'h00;
      end
   end
   sequence s_high10;
      o_quad_out_a [*8] ##1 o_quad_out_a [*2] ##1 !o_quad_out_a;
   endsequence
   sequence s_hold10;
      $stable({o_quad_out_a, o_quad_out_b}) [*8] ##1 $stable({o_quad_out_a, o_quad_out_b});
   endsequence
   property p_step_high; $rose(o_quad_out_a) && i_encoder_mode_sel |-> s_high10; endproperty
   a_step_high: assert property (p_step_high) else $error("step high time wrong");
   property p_hold; !i_encoder_mode_sel && $changed({o_quad_out_a, o_quad_out_b}) |=> s_hold10; endproperty
   a_hold: assert property (p_hold) else $error("quad state held too short");
   property p_gray; !i_encoder_mode_sel |-> $countones({o_quad_out_a, o_quad_out_b} ^ $past({o_quad_out_a, o_quad_out_b})) <= 1; endproperty
   a_gray: assert property (p_gray) else $error("both channels moved at once");
   property p_dir; i_encoder_mode_sel && o_quad_out_a && $past(o_quad_out_a) |-> $stable(o_quad_out_b); endproperty
   a_dir: assert property (p_dir) else $error("direction moved mid pulse");
   property p_gap; $rose(o_quad_out_a) |-> gap_ff >= 8'h13; endproperty
   a_gap: assert property (p_gap) else $error("A rate too high");
   property p_index; $fell(o_index_out) |-> hi_ff == 8'h64; endproperty
   a_index: assert property (p_index) else $error("index width wrong");
   property p_quiet; !o_startup_done |-> !o_index_out; endproperty
   a_quiet: assert property (p_quiet) else $error("index during startup");
   property p_done; o_startup_done |=> o_startup_done; endproperty
   a_done: assert property (p_done) else $error("startup flag dropped");
endmodule
bind qee_top qee_top_properties chk_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
   .i_angle_value(i_angle_value), .i_angle_valid(i_angle_valid),
   .i_step_resolution_sel(i_step_resolution_sel), .i_encoder_mode_sel(i_encoder_mode_sel),
   .o_quad_out_a(o_quad_out_a), .o_quad_out_b(o_quad_out_b),
   .o_index_out(o_index_out), .o_startup_done(o_startup_done));

/* File: verif/quadrature_encoder_emulator_test.sv */
// Purpose : Self-checking bench for the encoder emulator with a counter model.
// Assumes : 20 MHz clock; random angles from a fixed seed.
// Notes   : Each phase resets, replays startup, then moves 80 steps back across zero and 41 forward.
`timescale 1ns/1ns
module quadrature_encoder_emulator_test;
   import qee_pkg::*;
   logic               clk, rst, valid, mode, qa, qb, idx, done;
   logic [ANG_W-1:0]   angle;
   logic [1:0]         res;
   logic signed [15:0] half;
   int                 miscompares, n_compared, tgt, rs, idx_hi_cyc, idx_base;
   qee_top dut_u (.i_mclk(clk), .i_sys_rst(rst), .i_angle_value(angle), .i_angle_valid(valid),
      .i_step_resolution_sel(res), .i_encoder_mode_sel(mode), .o_quad_out_a(qa),
      .o_quad_out_b(qb), .o_index_out(idx), .o_startup_done(done));
   qee_counter_model model_u (.i_mclk(clk), .i_sys_rst(rst), .i_a(qa), .i_b(qb),
      .i_mode(mode), .o_half_steps(half));
   // =========================================================
   // Shared comparison and closing tasks.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Position in steps of the chosen resolution, wrapped at one revolution.
   function automatic logic [15:0] wrap(input int s);
      return 16'(s & ((4096 >> rs) - 1));
   endfunction
   // Random sub-step bits must not move the count.
   task automatic go_to(input int s);
      @(posedge clk);
      angle <= ANG_W'((s << (3 + rs)) | ($urandom & ((8 << rs) - 1)));
      valid <= 1'b1;
      tgt = s;
      for (int j = 0; j < 4000 && wrap(half >>> 1) !== wrap(s); j++) @(posedge clk);
      repeat (120) @(posedge clk);
      check(wrap(half >>> 1), wrap(s));
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Cycles of index high; one zero crossing must give exactly one full-width pulse.
   always @(posedge clk) begin
      if (idx === 1'b1) idx_hi_cyc <= idx_hi_cyc + 1;
   end
   // The run needs about 30000 cycles.
   initial begin
      #(50 * 90000);
      miscompares++;
      print_verdict;
   end
   initial begin
      {rst, valid, mode, res, angle} = {1'b1, 19'h0_0000};
      miscompares = 0;
      n_compared = 0;
      void'($urandom(55));
      for (int k = 0; k < 8; k++) begin
         rst <= 1'b1;
         valid <= 1'b0;
         mode <= k[0];
         res <= 2'(k >> 1);
         rs = k >> 1;
         repeat (4) @(posedge clk);
         rst <= 1'b0;
         go_to(k == 0 ? 0 : (k == 7 ? 63 : $urandom_range(63, 1)));
         check(16'(done), 16'h0001);
         idx_base = idx_hi_cyc;
         go_to(tgt - 80);
         check(16'(idx_hi_cyc - idx_base), 16'(INDEX_CYC));
         go_to(tgt + 41);
         $display("phase %0d finished", k);
      end
      print_verdict;
   end
endmodule
